// *** timer_pkg.sv ***
// constants and carriers for the pwm / free-running timer channel
package timer_pkg;
  // ==========================================
  // register map
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  OPT_OFF       = 8'h04;
  localparam logic [7:0]  IOC1_OFF      = 8'h08;
  localparam logic [7:0]  FLAG_CLR_OFF  = 8'h0c;
  localparam logic [7:0]  CCR0_OFF      = 8'h10;
  localparam logic [7:0]  CCR1_OFF      = 8'h14;
  localparam logic [7:0]  CNT_OFF       = 8'h18;
  // ==========================================
  // fields and values
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          OPT_WRAP_BIT  = 7;
  localparam int          CLR_WRAP_BIT  = 0;
  localparam logic [2:0]  MODE_PWM      = 3'h4;
  localparam logic [2:0]  MODE_FREE     = 3'h5;
  localparam logic [15:0] CNT_IDLE      = 16'hffff;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CCR_RESET     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  // ==========================================
  // bus carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage : timer_pkg

// *** timer_pwm_free.sv ***
// timer channel with pwm and free-running modes behind an axi4-lite slave
`timescale 1ns/10ps
module timer_pwm_free (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  // register bus
  input  wire timer_pkg::axi_req_t  i_axi,
  output timer_pkg::axi_rsp_t       o_axi,
  // board side
  input  wire logic [1:0]           i_capture_in,
  output logic [1:0]                o_timer_out,
  output logic [1:0]                o_match_irq,
  output logic                      o_overflow_irq
);
  // ==========================================
  // state
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        run_reg;
  logic [2:0]  mode_reg;
  logic [1:0]  ccs_reg;
  logic [3:0]  edge_sel_reg;
  logic [15:0] ccr_reg [2];
  logic [15:0] period_sh_reg;
  logic [15:0] duty_sh_reg;
  logic        pending_reg;
  logic [15:0] cnt_reg;
  logic        started_reg;
  logic        wrap_reg;
  logic [1:0]  out_reg;
  logic [1:0]  irq_reg;
  logic        ovf_irq_reg;
  logic [1:0]  cap_prev_reg;
  // ==========================================
  // decode
  logic        wr_fire;
  logic        wr_hit;
  logic        clr_wr;
  logic [1:0]  ccr_wr;
  logic [1:0]  cap_ev;
  logic        pwm_act;
  logic        free_act;
  logic        pwm_clear;
  logic        free_wrap;
  logic        reload;
  logic [15:0] cnt_next;
  logic [15:0] period_next;
  logic [15:0] duty_next;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign o_axi = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                   bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                   rdata: rdata_reg, rresp: rresp_reg};
  assign o_timer_out    = out_reg;
  assign o_match_irq    = irq_reg;
  assign o_overflow_irq = ovf_irq_reg;

  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_hit  = awaddr_reg inside {timer_pkg::CTRL_OFF, timer_pkg::OPT_OFF,
                   timer_pkg::IOC1_OFF, timer_pkg::FLAG_CLR_OFF, timer_pkg::CCR0_OFF,
                   timer_pkg::CCR1_OFF, timer_pkg::CNT_OFF};
  assign clr_wr  = wr_fire && awaddr_reg == timer_pkg::FLAG_CLR_OFF && wstrb_reg[0]
                   && wdata_reg[timer_pkg::CLR_WRAP_BIT];
  assign ccr_wr[0] = wr_fire && awaddr_reg == timer_pkg::CCR0_OFF;
  assign ccr_wr[1] = wr_fire && awaddr_reg == timer_pkg::CCR1_OFF;

  // ==========================================
  // write channel
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= timer_pkg::RESP_OKAY;
    end else begin
      if (i_axi.awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= {i_axi.awaddr[7:2], 2'b00};
      end
      if (i_axi.wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= i_axi.wdata;
        wstrb_reg  <= i_axi.wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (bvalid_reg && i_axi.bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ==========================================
  // read channel
  always_comb begin
    rd_hit = 1'b1;
    case ({i_axi.araddr[7:2], 2'b00})
      timer_pkg::CTRL_OFF:     rd_mux = {28'h0, mode_reg, run_reg};
      timer_pkg::OPT_OFF:      rd_mux = {24'h0, wrap_reg, 5'h00, ccs_reg};
      timer_pkg::IOC1_OFF:     rd_mux = {28'h0, edge_sel_reg};
      timer_pkg::FLAG_CLR_OFF: rd_mux = 32'h0000_0000;
      timer_pkg::CCR0_OFF:     rd_mux = {16'h0, ccr_reg[0]};
      timer_pkg::CCR1_OFF:     rd_mux = {16'h0, ccr_reg[1]};
      timer_pkg::CNT_OFF:      rd_mux = {16'h0, cnt_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= timer_pkg::RESP_OKAY;
    end else if (i_axi.arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (rvalid_reg && i_axi.rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ==========================================
  // control registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg      <= 1'b0;
      mode_reg     <= 3'h0;
      ccs_reg      <= 2'h0;
      edge_sel_reg <= 4'h0;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == timer_pkg::CTRL_OFF) begin
        run_reg  <= wdata_reg[timer_pkg::CTRL_RUN_BIT];
        mode_reg <= wdata_reg[timer_pkg::CTRL_MODE_LSB +: 3];
      end
      if (awaddr_reg == timer_pkg::OPT_OFF) begin
        ccs_reg <= wdata_reg[1:0];
      end
      if (awaddr_reg == timer_pkg::IOC1_OFF) begin
        edge_sel_reg <= wdata_reg[3:0];
      end
    end
  end

  // ==========================================
  // counter control
  assign pwm_act   = run_reg && mode_reg == timer_pkg::MODE_PWM;
  assign free_act  = run_reg && mode_reg == timer_pkg::MODE_FREE;
  assign pwm_clear = pwm_act && (!started_reg || cnt_reg == period_sh_reg);
  assign free_wrap = free_act && started_reg && cnt_reg == timer_pkg::CNT_IDLE;
  assign reload    = pwm_clear && (!started_reg || pending_reg);

  always_comb begin
    if (!(pwm_act || free_act)) begin
      cnt_next = timer_pkg::CNT_IDLE;
    end else if (!started_reg || pwm_clear) begin
      cnt_next = timer_pkg::CNT_ZERO;
    end else begin
      cnt_next = 16'(cnt_reg + 16'h0001);
    end
  end

  assign period_next = reload ? ccr_reg[0] : period_sh_reg;
  assign duty_next   = reload ? ccr_reg[1] : duty_sh_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg     <= timer_pkg::CNT_IDLE;
      started_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      started_reg <= pwm_act || free_act;
    end
  end

  // ==========================================
  // pwm shadows
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_sh_reg <= timer_pkg::CCR_RESET;
      duty_sh_reg   <= timer_pkg::CCR_RESET;
      pending_reg   <= 1'b0;
    end else begin
      period_sh_reg <= period_next;
      duty_sh_reg   <= duty_next;
      if (ccr_wr[1]) begin
        pending_reg <= 1'b1;
      end else if (reload) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // wrap flag
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wrap_reg <= 1'b0;
    end else if (free_wrap) begin
      wrap_reg <= 1'b1;
    end else if (clr_wr) begin
      wrap_reg <= 1'b0;
    end
  end

  // ==========================================
  // per channel compare / capture registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_prev_reg <= 2'h0;
    end else begin
      cap_prev_reg <= i_capture_in;
    end
  end

  for (genvar n = 0; n < 2; n++) begin : g_chan
    logic [1:0] esel;
    logic       edge_seen;
    assign esel = edge_sel_reg[2*n +: 2];
    assign edge_seen = (esel == timer_pkg::EDGE_RISE && i_capture_in[n] && !cap_prev_reg[n])
                    || (esel == timer_pkg::EDGE_FALL && !i_capture_in[n] && cap_prev_reg[n])
                    || (esel == timer_pkg::EDGE_BOTH && i_capture_in[n] != cap_prev_reg[n]);
    // capture only in free-run, so io control 1 is ignored in pwm
    assign cap_ev[n] = free_act && started_reg && ccs_reg[n] && edge_seen;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ccr_reg[n] <= timer_pkg::CCR_RESET;
      end else if (cap_ev[n]) begin
        ccr_reg[n] <= cnt_reg;
      end else if (ccr_wr[n]) begin
        if (wstrb_reg[0]) begin
          ccr_reg[n][7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          ccr_reg[n][15:8] <= wdata_reg[15:8];
        end
      end
    end
  end

  // ==========================================
  // output pins and event pulses
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_reg     <= 2'h0;
      irq_reg     <= 2'h0;
      ovf_irq_reg <= 1'b0;
    end else if (pwm_act) begin
      out_reg[1]  <= cnt_next < duty_next;
      if (pwm_clear) begin
        out_reg[0] <= !out_reg[0];
      end
      irq_reg[0]  <= pwm_clear && started_reg;
      irq_reg[1]  <= cnt_next == duty_next;
      ovf_irq_reg <= 1'b0;
    end else if (free_act) begin
      for (int k = 0; k < 2; k++) begin
        if (!started_reg) begin
          out_reg[k] <= !out_reg[k];
          irq_reg[k] <= 1'b0;
        end else if (!ccs_reg[k]) begin
          irq_reg[k] <= cnt_reg == ccr_reg[k];
          if (cnt_reg == ccr_reg[k]) begin
            out_reg[k] <= !out_reg[k];
          end
        end else begin
          irq_reg[k] <= cap_ev[k];
        end
      end
      ovf_irq_reg <= free_wrap;
    end else begin
      out_reg     <= 2'h0;
      irq_reg     <= 2'h0;
      ovf_irq_reg <= 1'b0;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_idle_top;
    cnt_reg == timer_pkg::CNT_IDLE;
  endsequence
  sequence s_cleared;
    cnt_reg == timer_pkg::CNT_ZERO;
  endsequence

  property p_pwm_start;
    (pwm_act && !started_reg) |-> s_idle_top ##1 s_cleared;
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("pwm start not ffff to 0");

  property p_period_irq;
    (pwm_act && started_reg && cnt_reg == period_sh_reg) |=> (irq_reg[0] and s_cleared);
  endproperty
  a_period_irq: assert property (p_period_irq) else $error("match 0 not with clear");

  property p_duty_irq;
    (pwm_act && started_reg && $past(pwm_act) && $past(started_reg)
      && cnt_reg == duty_sh_reg) |-> irq_reg[1];
  endproperty
  a_duty_irq: assert property (p_duty_irq) else $error("match 1 not on duty");

  property p_no_reload;
    (pwm_act && started_reg && !pending_reg && !ccr_wr[1]) |=> $stable(duty_sh_reg);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("shadow loaded unwritten");

  property p_pwm_high;
    (pwm_act && started_reg && $past(pwm_act) && cnt_reg == timer_pkg::CNT_ZERO
      && duty_sh_reg != timer_pkg::CNT_ZERO) |-> out_reg[1];
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("pwm not high at zero");

  property p_free_start;
    (free_act && !started_reg) |=> out_reg == ~$past(out_reg);
  endproperty
  a_free_start: assert property (p_free_start) else $error("start did not invert");

  property p_free_cmp;
    (free_act && started_reg && !ccs_reg[0] && cnt_reg == ccr_reg[0])
      |=> (irq_reg[0] && out_reg[0] != $past(out_reg[0]));
  endproperty
  a_free_cmp: assert property (p_free_cmp) else $error("compare 0 missed");

  property p_wrap;
    free_wrap |=> ((ovf_irq_reg && wrap_reg) and s_cleared);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not signalled");

  property p_flag_hold;
    (wrap_reg && !clr_wr) |=> wrap_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("wrap flag lost");

  property p_capture;
    cap_ev[1] |=> (ccr_reg[1] == $past(cnt_reg) && irq_reg[1]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture 1 wrong");

  property p_cnt_read;
    (i_axi.arvalid && arready_reg && {i_axi.araddr[7:2], 2'b00} == timer_pkg::CNT_OFF)
      |=> (rvalid_reg && rdata_reg[15:0] == $past(cnt_reg));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("counter read wrong");

  property p_out0_toggle;
    (pwm_act && started_reg && cnt_reg == period_sh_reg)
      |=> (out_reg[0] != $past(out_reg[0]));
  endproperty
  a_out0_toggle: assert property (p_out0_toggle) else $error("pin 0 did not toggle");

  property p_zero_duty;
    (pwm_act && duty_next == timer_pkg::CNT_ZERO) |=> !out_reg[1];
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty drove pin 1");
endmodule : timer_pwm_free

// *** edge_src_load.sv ***
// partner model: edge source on the capture inputs, load on the pins
`timescale 1ns/10ps
module edge_src_load (
  // clock
  input  wire logic       i_clk,
  // pins from the timer
  input  wire logic [1:0] i_pins,
  // edge sources, idle low as with a pull-down
  output logic [1:0]      o_edges,
  output int              o_flips
);
  // ==========================================
  // load: counts level changes on pin 0
  logic [1:0] edges_q = 2'h0;
  int         flips_q = 0;
  logic       last0   = 1'b0;
  assign o_edges = edges_q;
  assign o_flips = flips_q;
  always @(posedge i_clk) begin
    if (i_pins[0] !== last0) begin
      flips_q <= flips_q + 1;
    end
    last0 <= i_pins[0];
  end
  // ==========================================
  // one rising edge, held long enough to be seen
  task automatic pulse(input int ch);
    @(posedge i_clk);
    edges_q[ch] <= 1'b1;
    repeat (3) @(posedge i_clk);
    edges_q[ch] <= 1'b0;
  endtask : pulse
endmodule : edge_src_load

// *** test_timer_pwm_free.sv ***
// self-checking bench for the pwm / free-running timer channel
`timescale 1ns/10ps
module test_timer_pwm_free;
  // ==========================================
  // signals
  typedef struct packed {
    logic        w0;
    logic [15:0] c0;
    logic        w1;
    logic [15:0] c1;
    int          per;
    int          hi;
    int          m1;
  } row_t;
  logic                ref_clk;
  logic                rst_n;
  timer_pkg::axi_req_t req;
  timer_pkg::axi_rsp_t rsp;
  logic [1:0]          cap;
  logic [1:0]          tout;
  logic [1:0]          mi;
  logic                ovf;
  int                  flips;
  int                  err_total = 0;
  int                  n_tests = 0;
  row_t                rows [5];
  logic [7:0]          raddr [8];
  logic [31:0]         rv;
  logic [15:0]         c1;
  logic [15:0]         c2;
  int                  per;
  int                  hi;
  int                  m1;
  int                  t0;
  int                  f;
  timer_pwm_free uut (
    .i_ref_clk      (ref_clk),
    .i_rst_n        (rst_n),
    .i_axi          (req),
    .o_axi          (rsp),
    .i_capture_in   (cap),
    .o_timer_out    (tout),
    .o_match_irq    (mi),
    .o_overflow_irq (ovf)
  );
  edge_src_load load (
    .i_clk   (ref_clk),
    .i_pins  (tout),
    .o_edges (cap),
    .o_flips (flips)
  );
  always #2 ref_clk = ~ref_clk;
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] exp_resp(input logic [7:0] a);
    return {30'h0, (a <= timer_pkg::CNT_OFF) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR};
  endfunction : exp_resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic done;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.bready  <= 1'b1;
    n = 0;
    done = 1'b0;
    while (!done && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        done = 1'b1;
        req.bready <= 1'b0;
        chk("bresp", exp_resp(a), {30'h0, rsp.bresp});
      end
    end
    chk("b_done", 32'h1, {31'h0, done});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int   n;
    logic done;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    n = 0;
    done = 1'b0;
    d = 32'h0;
    while (!done && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        done = 1'b1;
        d = rsp.rdata;
        req.rready <= 1'b0;
        chk("rresp", exp_resp(a), {30'h0, rsp.rresp});
      end
    end
    chk("r_done", 32'h1, {31'h0, done});
  endtask : rd
  task automatic wait_ev(input int k, input int lim);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge ref_clk);
      n++;
      case (k)
        0: hit = (mi[0] === 1'b1);
        1: hit = (mi[1] === 1'b1);
        2: hit = (ovf === 1'b1);
        default: hit = (tout === 2'h3);
      endcase
    end
    chk("event", 32'h1, {31'h0, hit});
  endtask : wait_ev
  task automatic meas(output int p, output int h, output int m, output int t);
    logic o0;
    p = 0;
    h = 0;
    m = 0;
    t = 0;
    repeat (2) wait_ev(0, 300);
    o0 = tout[0];
    do begin
      @(posedge ref_clk);
      p++;
      h += (tout[1] === 1'b1);
      m += (mi[1] === 1'b1);
      t += (tout[0] !== o0);
      o0 = tout[0];
    end while (mi[0] !== 1'b1 && p < 300);
  endtask : meas
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // ==========================================
  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    raddr = '{timer_pkg::CTRL_OFF, timer_pkg::OPT_OFF, timer_pkg::IOC1_OFF,
              timer_pkg::FLAG_CLR_OFF, timer_pkg::CCR0_OFF, timer_pkg::CCR1_OFF,
              timer_pkg::CNT_OFF, 8'h1c};
    rows[0] = '{1'b0, 16'h0009, 1'b0, 16'h0003, 10, 3, 1};
    rows[1] = '{1'b0, 16'h0009, 1'b1, 16'h0000, 10, 0, 1};
    rows[2] = '{1'b0, 16'h0009, 1'b1, 16'h000a, 10, 10, 0};
    rows[3] = '{1'b1, 16'h0005, 1'b0, 16'h000a, 10, 10, 0};
    rows[4] = '{1'b0, 16'h0005, 1'b1, 16'h0002, 6, 2, 1};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (raddr[i]) begin
      rd(raddr[i], rv);
      chk("rst_val", (i == 6) ? 32'hffff : 32'h0, rv);
    end
    wr(timer_pkg::CCR0_OFF, 32'h9);
    wr(timer_pkg::CCR1_OFF, 32'h3);
    wr(timer_pkg::OPT_OFF, 32'h3);
    wr(timer_pkg::IOC1_OFF, 32'hff);
    wr(timer_pkg::CTRL_OFF, {28'h0, timer_pkg::MODE_PWM, 1'b1});
    rd(timer_pkg::CNT_OFF, rv);
    chk("start_cnt", 32'h1, {31'h0, rv <= 32'h9});
    foreach (rows[i]) begin
      if (rows[i].w0) wr(timer_pkg::CCR0_OFF, {16'h0, rows[i].c0});
      if (rows[i].w1) wr(timer_pkg::CCR1_OFF, {16'h0, rows[i].c1});
      meas(per, hi, m1, t0);
      chk("period", rows[i].per, per);
      chk("active", rows[i].hi, hi);
      chk("duty_irq", rows[i].m1, m1);
      chk("out0_flip", 32'h1, t0);
    end
    load.pulse(0);
    load.pulse(1);
    rd(timer_pkg::CCR0_OFF, rv);
    chk("pwm_ccr0", 32'h5, rv);
    rd(timer_pkg::CCR1_OFF, rv);
    chk("pwm_ccr1", 32'h2, rv);
    wr(timer_pkg::CTRL_OFF, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("stop_pins", 32'h0, {30'h0, tout});
    wr(timer_pkg::OPT_OFF, 32'h2);
    wr(timer_pkg::IOC1_OFF, 32'h4);
    wr(timer_pkg::CCR0_OFF, 32'h100);
    wr(timer_pkg::CTRL_OFF, {28'h0, timer_pkg::MODE_FREE, 1'b1});
    wait_ev(3, 8);
    @(posedge ref_clk);
    f = flips;
    wait_ev(0, 400);
    repeat (2) @(posedge ref_clk);
    chk("cmp_pin", 32'h0, {31'h0, tout[0]});
    chk("cmp_flips", f + 1, flips);
    rd(timer_pkg::CNT_OFF, rv);
    c1 = rv[15:0] + 16'h40;
    wr(timer_pkg::CCR0_OFF, {16'h0, c1});
    wait_ev(0, 200);
    rd(timer_pkg::CNT_OFF, rv);
    c2 = rv[15:0] - c1;
    chk("live_cmp", 32'h1, {31'h0, c2 < 16'h10});
    rd(timer_pkg::CNT_OFF, rv);
    c1 = rv[15:0];
    fork
      load.pulse(1);
      wait_ev(1, 8);
    join
    rd(timer_pkg::CCR1_OFF, rv);
    c2 = rv[15:0];
    rd(timer_pkg::CNT_OFF, rv);
    chk("capture", 32'h1, {31'h0, (c2 > c1) && (rv[15:0] > c2)});
    wait_ev(2, 70000);
    rd(timer_pkg::CNT_OFF, rv);
    chk("wrap_cnt", 32'h1, {31'h0, rv < 32'h20});
    repeat (2) begin
      rd(timer_pkg::OPT_OFF, rv);
      chk("wrap_set", 32'h1, {31'h0, rv[timer_pkg::OPT_WRAP_BIT]});
    end
    wr(timer_pkg::FLAG_CLR_OFF, 32'h1);
    rd(timer_pkg::OPT_OFF, rv);
    chk("wrap_clr", 32'h0, {31'h0, rv[timer_pkg::OPT_WRAP_BIT]});
    wr(8'h1c, 32'h1);
    wrap_up();
  end
endmodule : test_timer_pwm_free
